// file: logic/sdtmr_pkg.sv
// register map, field layout and reset values of the split dual 8-bit timer
`default_nettype none
package sdtmr_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_CONTROL_A = 6'h00;
  localparam logic [5:0] IDX_SPLIT_CONTROL = 6'h03;
  localparam logic [5:0] IDX_CTRL_E_CLEAR = 6'h04;
  localparam logic [5:0] IDX_CTRL_E_SET = 6'h05;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h0a;
  localparam logic [5:0] IDX_INT_FLAGS = 6'h0b;
  localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h0e;
  localparam logic [5:0] IDX_LOW_COUNT = 6'h20;
  localparam logic [5:0] IDX_HIGH_COUNT = 6'h21;
  localparam logic [5:0] IDX_LOW_PERIOD = 6'h26;
  localparam logic [5:0] IDX_HIGH_PERIOD = 6'h27;
  localparam logic [5:0] IDX_LOW_CMP0 = 6'h28;
  localparam logic [5:0] IDX_HIGH_CMP0 = 6'h29;
  localparam logic [5:0] IDX_CMP_STRIDE = 6'h02;
  localparam logic [5:0] IDX_SPLIT_FIRST = 6'h20;
  localparam int NUM_CMP = 3;

  // ==========================================================
  // field positions
  localparam int POS_ENABLE = 0;
  localparam int POS_PRESCALE = 1;
  localparam int POS_CMD = 2;
  localparam int POS_TARGET = 0;
  localparam int POS_LOW_UNF = 0;
  localparam int POS_HIGH_UNF = 1;
  localparam int POS_LOW_CMP0 = 4;
  localparam logic [7:0] IRQ_BIT_MASK = 8'h73;

  // ==========================================================
  // commands and targets
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;
  localparam logic [1:0] TARGET_NONE = 2'h0;
  localparam logic [1:0] TARGET_BOTH = 2'h3;

  // ==========================================================
  // reset values and bus answers
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PRESC_W = 10;

  // low bits of the prescaler that must be zero for a tick
  function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] sel);
    case (sel)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00f;
      3'h5: presc_mask = 10'h03f;
      3'h6: presc_mask = 10'h0ff;
      default: presc_mask = 10'h3ff;
    endcase
  endfunction : presc_mask
endpackage : sdtmr_pkg
`default_nettype wire

// file: logic/sdtmr_split_timer.sv
// split dual 8-bit down-counter timer with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - split bit makes two independent 8-bit counters
// - split layout registers decode only in split
// - clear alias clears ones, reads control-E
// - set alias sets the written one bits
// - command 2 restarts, 3 hard resets
// - command field always reads back zero
// - hard reset ignored while timer enabled
// - target 3 selects both counters, others none
// - low compare enables gate compare flags to irq
// - underflow enables gate underflow flags to irq
// - low compare flag set on count match
// - flags stay set until written one
// - high underflow flag set at bottom
// - low underflow flag set at bottom
// - debug halt freezes timer unless run bit
// - run bit keeps counting during debug halt
// - bus write to low count wins
// - low count live, read-write, resets zero
// - high count live, resets zero, write wins
// - period registers hold top, reset all ones
// - compare registers compared against own counter
// - prescale select divides by 1 to 1024
module sdtmr_split_timer #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_halt,
  output logic int_request
);
  // ==========================================================
  // parameter check
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("sdtmr_split_timer: ADDR_W must be at least 8");
    end
  endgenerate

  // ==========================================================
  // state
  typedef struct packed {
    logic enable;
    logic [2:0] prescale_select;
    logic split_mode_select;
    logic [1:0] command_target_select;
    logic [7:0] int_enable;
    logic [7:0] int_flags;
    logic run_while_debug_halted;
    logic [7:0] low_byte_count;
    logic [7:0] high_byte_count;
    logic [7:0] low_byte_period;
    logic [7:0] high_byte_period;
    logic [2:0][7:0] low_compare_channel;
    logic [2:0][7:0] high_compare_channel;
    logic [sdtmr_pkg::PRESC_W-1:0] presc;
    logic irq;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdtmr_state_t;

  sdtmr_state_t s_reg;
  sdtmr_state_t s_next;

  // ==========================================================
  // write decode: performed once both address and data are held
  logic wr_go;
  logic wr_hit;
  logic [5:0] wr_idx;
  logic [7:0] wr_val;
  logic wr_en;
  logic halted;
  logic run;
  logic tick;
  logic [1:0] cmd_issued;
  logic [1:0] target_after;
  logic restart_cmd;
  logic hard_cmd;
  logic [2:0] low_match;
  logic [2:0] high_match;

  assign wr_go = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
  assign wr_idx = s_reg.aw_addr[7:2];
  assign wr_hit = addr_ok(s_reg.aw_addr, s_reg.split_mode_select);
  assign wr_en = wr_go && wr_hit && s_reg.w_lane0;
  assign wr_val = s_reg.w_data;

  // commands only come through the set alias; the clear alias can only
  // drive the always-zero field to zero, which is no command
  assign cmd_issued = (wr_en && wr_idx == sdtmr_pkg::IDX_CTRL_E_SET) ?
    wr_val[sdtmr_pkg::POS_CMD +: 2] : sdtmr_pkg::CMD_NONE;
  assign target_after = (wr_en && wr_idx == sdtmr_pkg::IDX_CTRL_E_SET) ?
    (s_reg.command_target_select | wr_val[1:0]) :
    s_reg.command_target_select;
  // command acts on the target as it stands after the same write; only both is a target
  assign restart_cmd = cmd_issued == sdtmr_pkg::CMD_RESTART &&
    target_after == sdtmr_pkg::TARGET_BOTH;
  assign hard_cmd = cmd_issued == sdtmr_pkg::CMD_HARD_RESET &&
    target_after == sdtmr_pkg::TARGET_BOTH && !s_reg.enable;

  // debug halt freezes prescaler and counters unless told to run
  assign halted = debug_halt && !s_reg.run_while_debug_halted;
  assign run = s_reg.enable && s_reg.split_mode_select && !halted;
  assign tick = run && ((s_reg.presc &
    sdtmr_pkg::presc_mask(s_reg.prescale_select)) == '0);

  // per-channel comparators on each byte counter
  generate
    for (genvar n = 0; n < sdtmr_pkg::NUM_CMP; n++) begin : g_cmp
      assign low_match[n] = s_reg.low_byte_count ==
        s_reg.low_compare_channel[n];
      assign high_match[n] = s_reg.high_byte_count ==
        s_reg.high_compare_channel[n];
    end
  endgenerate

  // ==========================================================
  // address map helpers
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a,
                                   input logic split);
    logic [5:0] i;
    logic ok;
    i = a[7:2];
    ok = 1'b0;
    if (a[1:0] == 2'h0 && (a >> 8) == '0) begin
      case (i)
        sdtmr_pkg::IDX_CONTROL_A, sdtmr_pkg::IDX_SPLIT_CONTROL,
        sdtmr_pkg::IDX_CTRL_E_CLEAR, sdtmr_pkg::IDX_CTRL_E_SET,
        sdtmr_pkg::IDX_INT_ENABLE, sdtmr_pkg::IDX_INT_FLAGS,
        sdtmr_pkg::IDX_DEBUG_CONTROL: ok = 1'b1;
        // split-only layout is hidden in normal mode
        default: ok = split && i >= sdtmr_pkg::IDX_SPLIT_FIRST &&
          i <= sdtmr_pkg::IDX_HIGH_CMP0 + 6'h04 &&
          i != 6'h22 && i != 6'h23 && i != 6'h24 && i != 6'h25;
      endcase
    end
    addr_ok = ok;
  endfunction : addr_ok

  function automatic logic [7:0] read_val(input sdtmr_state_t s,
                                          input logic [5:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      sdtmr_pkg::IDX_CONTROL_A: v = {4'h0, s.prescale_select, s.enable};
      sdtmr_pkg::IDX_SPLIT_CONTROL: v = {7'h00, s.split_mode_select};
      // command field is never stored, so it reads zero
      sdtmr_pkg::IDX_CTRL_E_CLEAR,
      sdtmr_pkg::IDX_CTRL_E_SET: v = {6'h00, s.command_target_select};
      sdtmr_pkg::IDX_INT_ENABLE: v = s.int_enable;
      sdtmr_pkg::IDX_INT_FLAGS: v = s.int_flags;
      sdtmr_pkg::IDX_DEBUG_CONTROL: v = {7'h00, s.run_while_debug_halted};
      sdtmr_pkg::IDX_LOW_COUNT: v = s.low_byte_count;
      sdtmr_pkg::IDX_HIGH_COUNT: v = s.high_byte_count;
      sdtmr_pkg::IDX_LOW_PERIOD: v = s.low_byte_period;
      sdtmr_pkg::IDX_HIGH_PERIOD: v = s.high_byte_period;
      6'h28: v = s.low_compare_channel[0];
      6'h29: v = s.high_compare_channel[0];
      6'h2a: v = s.low_compare_channel[1];
      6'h2b: v = s.high_compare_channel[1];
      6'h2c: v = s.low_compare_channel[2];
      6'h2d: v = s.high_compare_channel[2];
      default: v = 8'h00;
    endcase
    read_val = v;
  endfunction : read_val

  // ==========================================================
  // next state
  always_comb begin
    logic [7:0] set_flags;
    logic [7:0] clr_flags;
    set_flags = 8'h00;
    clr_flags = 8'h00;
    s_next = s_reg;

    // prescaler: frozen while not running, cleared by restart
    if (run) begin
      s_next.presc = s_reg.presc + 10'h001;
    end
    if (restart_cmd || hard_cmd) begin
      s_next.presc = '0;
    end

    // counters count down and reload from period after zero
    if (tick) begin
      if (s_reg.low_byte_count == 8'h00) begin
        s_next.low_byte_count = s_reg.low_byte_period;
        set_flags[sdtmr_pkg::POS_LOW_UNF] = 1'b1;
      end else begin
        s_next.low_byte_count = s_reg.low_byte_count - 8'h01;
      end
      if (s_reg.high_byte_count == 8'h00) begin
        s_next.high_byte_count = s_reg.high_byte_period;
        set_flags[sdtmr_pkg::POS_HIGH_UNF] = 1'b1;
      end else begin
        s_next.high_byte_count = s_reg.high_byte_count - 8'h01;
      end
      set_flags[sdtmr_pkg::POS_LOW_CMP0 +: 3] = low_match;
    end

    // restart touches only the counters and prescaler; hard reset also the periods and compares
    if (restart_cmd || hard_cmd) begin
      s_next.low_byte_count = sdtmr_pkg::RST_COUNT;
      s_next.high_byte_count = sdtmr_pkg::RST_COUNT;
    end
    if (hard_cmd) begin
      s_next.low_byte_period = sdtmr_pkg::RST_PERIOD;
      s_next.high_byte_period = sdtmr_pkg::RST_PERIOD;
      s_next.low_compare_channel = '0;
      s_next.high_compare_channel = '0;
    end

    // register writes come last so they win over counting
    if (wr_en) begin
      case (wr_idx)
        sdtmr_pkg::IDX_CONTROL_A: begin
          s_next.enable = wr_val[sdtmr_pkg::POS_ENABLE];
          s_next.prescale_select = wr_val[sdtmr_pkg::POS_PRESCALE +: 3];
        end
        sdtmr_pkg::IDX_SPLIT_CONTROL: begin
          s_next.split_mode_select = wr_val[0];
        end
        sdtmr_pkg::IDX_CTRL_E_CLEAR: begin
          s_next.command_target_select =
            s_reg.command_target_select & ~wr_val[1:0];
        end
        sdtmr_pkg::IDX_CTRL_E_SET: begin
          s_next.command_target_select = target_after;
        end
        sdtmr_pkg::IDX_INT_ENABLE: begin
          s_next.int_enable = wr_val & sdtmr_pkg::IRQ_BIT_MASK;
        end
        sdtmr_pkg::IDX_INT_FLAGS: begin
          clr_flags = wr_val & sdtmr_pkg::IRQ_BIT_MASK;
        end
        sdtmr_pkg::IDX_DEBUG_CONTROL: begin
          s_next.run_while_debug_halted = wr_val[0];
        end
        sdtmr_pkg::IDX_LOW_COUNT: begin
          s_next.low_byte_count = wr_val;
        end
        sdtmr_pkg::IDX_HIGH_COUNT: begin
          s_next.high_byte_count = wr_val;
        end
        sdtmr_pkg::IDX_LOW_PERIOD: begin
          s_next.low_byte_period = wr_val;
        end
        sdtmr_pkg::IDX_HIGH_PERIOD: begin
          s_next.high_byte_period = wr_val;
        end
        6'h28: s_next.low_compare_channel[0] = wr_val;
        6'h29: s_next.high_compare_channel[0] = wr_val;
        6'h2a: s_next.low_compare_channel[1] = wr_val;
        6'h2b: s_next.high_compare_channel[1] = wr_val;
        6'h2c: s_next.low_compare_channel[2] = wr_val;
        6'h2d: s_next.high_compare_channel[2] = wr_val;
        default: ;
      endcase
    end

    // a flag set in the clearing cycle survives
    s_next.int_flags = ((s_reg.int_flags & ~clr_flags) | set_flags) &
      sdtmr_pkg::IRQ_BIT_MASK;
    s_next.irq = |(s_reg.int_flags & s_reg.int_enable);

    // write channels: hold address and data until both are here
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_hit ? sdtmr_pkg::RESP_OKAY : sdtmr_pkg::RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready = !s_next.w_full && !s_next.bvalid;

    // read channel: one outstanding read, answered the next cycle
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      if (addr_ok(s_axi_araddr, s_reg.split_mode_select)) begin
        s_next.rdata = {24'h000000, read_val(s_reg, s_axi_araddr[7:2])};
        s_next.rresp = sdtmr_pkg::RESP_OKAY;
      end else begin
        s_next.rdata = 32'h00000000;
        s_next.rresp = sdtmr_pkg::RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = !s_next.rvalid;
  end

  // ==========================================================
  // state register; synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.low_byte_period <= sdtmr_pkg::RST_PERIOD;
      s_reg.high_byte_period <= sdtmr_pkg::RST_PERIOD;
      s_reg.low_byte_count <= sdtmr_pkg::RST_COUNT;
      s_reg.high_byte_count <= sdtmr_pkg::RST_COUNT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign int_request = s_reg.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_low_byte_count_write;
    wr_en && wr_idx == sdtmr_pkg::IDX_LOW_COUNT;
  endsequence
  sequence s_low_free_tick;
    tick && !restart_cmd && !hard_cmd &&
      !(wr_en && wr_idx == sdtmr_pkg::IDX_LOW_COUNT);
  endsequence

  property p_cmd_reads_zero;
    s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == ADDR_W'(4 * sdtmr_pkg::IDX_CTRL_E_SET)
      |=> s_axi_rvalid && s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command field read back non-zero");

  property p_hard_ignored;
    cmd_issued == sdtmr_pkg::CMD_HARD_RESET && s_reg.enable
      |=> s_reg.low_byte_period == $past(s_reg.low_byte_period);
  endproperty
  a_hard_ignored: assert property (p_hard_ignored)
    else $error("hard reset acted while enabled");

  property p_flag_sticky;
    s_reg.int_flags[sdtmr_pkg::POS_LOW_UNF] &&
      !(wr_en && wr_idx == sdtmr_pkg::IDX_INT_FLAGS)
      |=> s_reg.int_flags[sdtmr_pkg::POS_LOW_UNF];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("underflow flag dropped without a clear");

  property p_low_underflow;
    s_low_free_tick ##0 s_reg.low_byte_count == 8'h00
      |=> s_reg.int_flags[sdtmr_pkg::POS_LOW_UNF] &&
        s_reg.low_byte_count == $past(s_reg.low_byte_period);
  endproperty
  a_low_underflow: assert property (p_low_underflow)
    else $error("low counter bottom not handled");

  property p_low_decrement;
    s_low_free_tick ##0 s_reg.low_byte_count != 8'h00
      |=> s_reg.low_byte_count == $past(s_reg.low_byte_count) - 8'h01;
  endproperty
  a_low_decrement: assert property (p_low_decrement)
    else $error("low counter did not step down");

  property p_write_wins;
    s_low_byte_count_write |=> s_reg.low_byte_count == $past(wr_val);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("low count write lost");

  property p_debug_freeze;
    halted && !wr_en && !restart_cmd && !hard_cmd
      |=> s_reg.low_byte_count == $past(s_reg.low_byte_count);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze)
    else $error("counter moved in debug halt");

  property p_irq_gate;
    (s_reg.int_flags & s_reg.int_enable) != 8'h00 |=> int_request;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("enabled flag raised no interrupt request");

  property p_clear_alias;
    wr_en && wr_idx == sdtmr_pkg::IDX_CTRL_E_CLEAR |=>
      s_reg.command_target_select ==
        ($past(s_reg.command_target_select) & ~$past(wr_val[1:0]));
  endproperty
  a_clear_alias: assert property (p_clear_alias)
    else $error("clear alias changed other bits");
endmodule : sdtmr_split_timer

`default_nettype wire

// file: dv/sdtmr_tb.sv
// self-checking bench for the split dual 8-bit timer register slave
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // clock, reset and design ports
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, debug_halt = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, int_request;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] last_bresp = 2'h0;
  int num_errors = 0;
  int checks_done = 0;
  // short aliases for register indices and answers
  localparam logic [5:0] I_CA = sdtmr_pkg::IDX_CONTROL_A;
  localparam logic [5:0] I_SP = sdtmr_pkg::IDX_SPLIT_CONTROL;
  localparam logic [5:0] I_CLR = sdtmr_pkg::IDX_CTRL_E_CLEAR;
  localparam logic [5:0] I_SET = sdtmr_pkg::IDX_CTRL_E_SET;
  localparam logic [5:0] I_IE = sdtmr_pkg::IDX_INT_ENABLE;
  localparam logic [5:0] I_IF = sdtmr_pkg::IDX_INT_FLAGS;
  localparam logic [5:0] I_DBG = sdtmr_pkg::IDX_DEBUG_CONTROL;
  localparam logic [5:0] I_LC = sdtmr_pkg::IDX_LOW_COUNT;
  localparam logic [5:0] I_HC = sdtmr_pkg::IDX_HIGH_COUNT;
  localparam logic [5:0] I_LP = sdtmr_pkg::IDX_LOW_PERIOD;
  localparam logic [5:0] I_HP = sdtmr_pkg::IDX_HIGH_PERIOD;
  localparam logic [5:0] I_C0 = sdtmr_pkg::IDX_LOW_CMP0;
  localparam logic [1:0] OK = sdtmr_pkg::RESP_OKAY;
  localparam logic [1:0] ER = sdtmr_pkg::RESP_SLVERR;

  sdtmr_split_timer #(.ADDR_W(8)) sdtmr_split_timer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .debug_halt(debug_halt), .int_request(int_request)
  );

  // 50 ns period
  always #25 aclk = ~aclk;

  // ==========================================================
  // comparison and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] expd,
                       input string what);
    checks_done++;
    if (seen !== expd) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, seen,
               expd);
    end
  endtask : check

  // ready is read before the edge's updates land, so the take is seen
  task automatic bus_wr(input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    last_bresp = s_axi_bresp;
    if (n >= 100) num_errors++;
    s_axi_bready <= 1'b0;
    // one idle edge so the next request never lands in this time step
    @(posedge aclk);
  endtask : bus_wr

  task automatic bus_rd(input logic [5:0] idx, output logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 100) num_errors++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : bus_rd

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(idx, d, r);
    check(d, (er === OK) ? {24'h000000, e} : 32'h0, "read data");
    check({30'h0, r}, {30'h0, er}, "read resp");
  endtask : rd_chk

  task automatic irq_chk(input logic [7:0] en, input logic e);
    bus_wr(I_IE, en);
    repeat (2) @(posedge aclk);
    check({31'h0, int_request}, {31'h0, e}, "int_request");
  endtask : irq_chk

  // ==========================================================
  // scenarios
  task automatic t_map();
    // split-only register is hidden: write refused and ignored
    bus_wr(I_LC, 8'h77);
    check({30'h0, last_bresp}, {30'h0, ER}, "write resp");
    rd_chk(I_LC, 8'h00, ER);
    bus_wr(I_SP, 8'h01);
    check({30'h0, last_bresp}, {30'h0, OK}, "write resp");
    rd_chk(I_SP, 8'h01, OK);
    rd_chk(I_LC, 8'h00, OK);
    rd_chk(I_HC, 8'h00, OK);
    rd_chk(I_HP, 8'hff, OK);
    rd_chk(I_IE, 8'h00, OK);
    rd_chk(I_DBG, 8'h00, OK);
    rd_chk(6'h22, 8'h00, ER);
  endtask : t_map

  task automatic t_cmd();
    bus_wr(I_SET, 8'h03);
    rd_chk(I_CLR, 8'h03, OK);
    bus_wr(I_CLR, 8'h01);
    rd_chk(I_SET, 8'h02, OK);
    // reserved command code must do nothing
    bus_wr(I_SET, 8'h05);
    rd_chk(I_SET, 8'h03, OK);
    bus_wr(I_LC, 8'h55);
    bus_wr(I_HC, 8'h66);
    bus_wr(I_LP, 8'h12);
    bus_wr(I_CLR, 8'h03);
    bus_wr(I_SET, 8'h08);
    rd_chk(I_LC, 8'h55, OK);
    bus_wr(I_SET, 8'h0b);
    rd_chk(I_LC, 8'h00, OK);
    rd_chk(I_HC, 8'h00, OK);
    rd_chk(I_LP, 8'h12, OK);
    rd_chk(I_SET, 8'h03, OK);
    bus_wr(I_C0, 8'h34);
    bus_wr(I_CA, 8'h01);
    bus_wr(I_SET, 8'h0f);
    rd_chk(I_LP, 8'h12, OK);
    bus_wr(I_CA, 8'h00);
    bus_wr(I_SET, 8'h0f);
    rd_chk(I_LP, 8'hff, OK);
    rd_chk(I_C0, 8'h00, OK);
  endtask : t_cmd

  task automatic t_flags();
    bus_wr(I_IF, 8'hff);
    rd_chk(I_IF, 8'h00, OK);
    bus_wr(I_LP, 8'h03);
    bus_wr(I_HP, 8'h05);
    bus_wr(I_C0, 8'h03);
    bus_wr(I_C0 + 6'h04, 8'h80);
    // a short burst at div 1: underflow both, low count hits 0 and 3
    bus_wr(I_CA, 8'h01);
    bus_wr(I_CA, 8'h00);
    rd_chk(I_IF, 8'h33, OK);
    repeat (20) @(posedge aclk);
    bus_wr(I_IF, 8'h01);
    rd_chk(I_IF, 8'h32, OK);
    irq_chk(8'h01, 1'b0);
    irq_chk(8'h10, 1'b1);
    irq_chk(8'h02, 1'b1);
    irq_chk(8'h00, 1'b0);
  endtask : t_flags

  task automatic t_tick();
    // restart zeroes the prescaler so the first running cycle ticks
    bus_wr(I_SET, 8'h0b);
    bus_wr(I_LC, 8'h10);
    bus_wr(I_CA, 8'h0f);
    rd_chk(I_LC, 8'h0f, OK);
    repeat (1024) @(posedge aclk);
    rd_chk(I_LC, 8'h0e, OK);
    debug_halt <= 1'b1;
    repeat (1100) @(posedge aclk);
    rd_chk(I_LC, 8'h0e, OK);
    bus_wr(I_DBG, 8'h01);
    // prescaler resumes from its frozen phase: exactly one tick in the wait
    repeat (1500) @(posedge aclk);
    rd_chk(I_LC, 8'h0d, OK);
    // at div 1 a tick meets the count write; the write must win
    bus_wr(I_CA, 8'h01);
    bus_wr(I_LC, 8'h40);
    rd_chk(I_LC, 8'h3e, OK);
    debug_halt <= 1'b0;
    bus_wr(I_CA, 8'h00);
    bus_wr(I_SP, 8'h00);
    rd_chk(I_LC, 8'h00, ER);
  endtask : t_tick

  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_map();
    t_cmd();
    t_flags();
    t_tick();
    finish_test();
  end

  // the run needs some 3900 cycles; five times that means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
